// ---- verilog/dac_decoder_consts.svh ----
`ifndef DAC_DECODER_CONSTS_SVH
`define DAC_DECODER_CONSTS_SVH

// apb register byte offsets
`define REG_INSTR       12'h000
`define REG_STATUS      12'h004
`define REG_CTRL        12'h008
`define REG_RB_INDEX    12'h00c
`define REG_RB_DATA     12'h010

// instruction word fields
`define INSTR_DATA_LSB  0
`define INSTR_DATA_MSB  13
`define INSTR_ADDR_LSB  14
`define INSTR_ADDR_MSB  21
`define INSTR_SEL_LSB   22
`define INSTR_SEL_MSB   23

// address sub-fields
`define ADDR_GRP_LSB    4
`define ADDR_GRP_MSB    7
`define ADDR_REG_LSB    0
`define ADDR_REG_MSB    3

// special-function fields
`define SFR_STEP_MSB    6
`define SFR_DIR_BIT     8
`define SFR_PAD_LSB     9
`define SFR_RST_CODE    14'h3fff

// status and control bits
`define STAT_BUSY_BIT   0
`define STAT_GND_BIT    1
`define CTRL_REL_BIT    0
`define RB_CH_MSB       4
`define RB_KIND_LSB     5
`define RB_KIND_MSB     6

// power-on values and code limits
`define INPUT_RST       14'h0000
`define OFFSET_RST      14'h2000
`define GAIN_RST        13'h1fff
`define CORR_RST        14'h0000
`define CODE_MAX        14'h3fff
`define OFFSET_MID      18'sh02000
`define GAIN_SHIFT      13

// timing
`define SYS_CLK_MHZ     250
`define SOFT_RST_NS     95000

`endif

// ---- verilog/dac_decoder_pkg.sv ----
package dac_decoder_pkg;
    typedef enum logic [1:0] {
        DEST_SPECIAL,
        DEST_GAIN,
        DEST_OFFSET,
        DEST_INPUT
    } dest_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DEC,
        ST_RUN,
        ST_SRST
    } state_e;

    typedef logic [13:0] code_t;
    typedef logic [12:0] gain_t;
endpackage

// ---- verilog/decode_if.sv ----
interface decode_if;
    import dac_decoder_pkg::*;
    logic [31:0] mask;
    dest_e       dest;
    code_t       data;
    logic        soft_rst;
    logic        sfr_ok;
    logic [6:0]  step;
    logic        step_up;

    modport dec (output mask, dest, data, soft_rst, sfr_ok, step, step_up);
    modport eng (input  mask, dest, data, soft_rst, sfr_ok, step, step_up);
endinterface

// ---- verilog/instr_decoder.sv ----
`include "dac_decoder_consts.svh"

module instr_decoder
    import dac_decoder_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // instruction in
    input  wire logic        load,
    input  wire logic [23:0] instr,
    // decoded out
    decode_if.dec            dq
);
    // register code to slot within group, 4'hf for none
    function automatic logic [3:0] slot_of(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: slot_of = code;
            4'h8:    slot_of = 4'h6;
            4'h9:    slot_of = 4'h7;
            default: slot_of = 4'hf;
        endcase
    endfunction

    logic [31:0] mask_d,  mask_q;
    dest_e       dest_d,  dest_q;
    code_t       data_d,  data_q;
    logic        srst_d,  srst_q;
    logic        sfrok_d, sfrok_q;
    logic [7:0]  addr;
    logic [3:0]  grp;
    logic [3:0]  slot;
    logic [31:0] grp_mask;

    assign addr = instr[`INSTR_ADDR_MSB:`INSTR_ADDR_LSB];
    assign grp  = addr[`ADDR_GRP_MSB:`ADDR_GRP_LSB];
    assign slot = slot_of(addr[`ADDR_REG_MSB:`ADDR_REG_LSB]);

    // each group bit covers eight channels, one per slot
    genvar g;
    genvar s;
    generate
        for (g = 0; g < 4; g++) begin : g_grp
            for (s = 0; s < 8; s++) begin : g_slot
                assign grp_mask[g*8+s] = grp[g] && (slot == 4'(s));
            end
        end
    endgenerate

    always_comb begin
        data_d  = instr[`INSTR_DATA_MSB:`INSTR_DATA_LSB];
        dest_d  = dest_e'(instr[`INSTR_SEL_MSB:`INSTR_SEL_LSB]);
        mask_d  = (grp == 4'h0) ? 32'hffff_ffff : grp_mask;
        srst_d  = (dest_d == DEST_SPECIAL) && (data_d == `SFR_RST_CODE);
        sfrok_d = (data_d[`INSTR_DATA_MSB:`SFR_PAD_LSB] == 5'h00)
                  && (data_d[`SFR_DIR_BIT-1] == 1'b0);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q  <= 32'h0000_0000;
            dest_q  <= DEST_SPECIAL;
            data_q  <= 14'h0000;
            srst_q  <= 1'b0;
            sfrok_q <= 1'b0;
        end else if (ce && load) begin
            mask_q  <= mask_d;
            dest_q  <= dest_d;
            data_q  <= data_d;
            srst_q  <= srst_d;
            sfrok_q <= sfrok_d;
        end
    end

    assign dq.mask     = mask_q;
    assign dq.dest     = dest_q;
    assign dq.data     = data_q;
    assign dq.soft_rst = srst_q;
    assign dq.sfr_ok   = sfrok_q;
    assign dq.step     = data_q[`SFR_STEP_MSB:0];
    assign dq.step_up  = data_q[`SFR_DIR_BIT];
endmodule

// ---- verilog/dac_write_decoder.sv ----
// Register access over APB and the register offsets were decided locally.
`include "dac_decoder_consts.svh"

module dac_write_decoder
    import dac_decoder_pkg::*;
#(
    parameter int SOFT_RST_CYCLES = (`SOFT_RST_NS * `SYS_CLK_MHZ) / 1000
)(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // status
    output logic             busy_n,
    output logic             at_ground
);
    localparam int CNT_W = $clog2(SOFT_RST_CYCLES + 1);

    // the counter, the storage and the instruction data field must agree
    generate
        if (SOFT_RST_CYCLES < 1) begin : g_chk
            $error("SOFT_RST_CYCLES must be at least one");
        end
        if (CNT_W > 31) begin : g_chk_cnt
            $error("SOFT_RST_CYCLES too large for the down-counter");
        end
        if ($bits(gain_t) != `GAIN_SHIFT) begin : g_chk_gain
            $error("gain code width does not match the gain shift");
        end
        if ($bits(code_t) != `INSTR_DATA_MSB - `INSTR_DATA_LSB + 1) begin : g_chk_code
            $error("code width does not match the instruction data field");
        end
    endgenerate

    // reset release synchroniser
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // state
    state_e             state_d,  state_q;
    logic [4:0]         ch_d,     ch_q;
    logic [CNT_W-1:0]   cnt_d,    cnt_q;
    logic               busy_n_d, busy_n_q;
    logic               gnd_d,    gnd_q;
    logic [6:0]         rb_d,     rb_q;
    logic [31:0]        rdata_d,  rdata_q;
    logic               ready_d,  ready_q;
    logic               err_d,    err_q;

    // channel storage
    code_t              input_mem [32];
    code_t              offset_mem[32];
    gain_t              gain_mem  [32];
    code_t              corr_mem  [32];
    code_t              input_d   [32];
    code_t              offset_d  [32];
    gain_t              gain_d    [32];
    code_t              corr_d    [32];

    logic               commit;
    logic               wr_instr;
    logic               mem_we;
    logic               mem_clr;
    logic               mapped;
    logic               hit_instr;
    logic               hit_stat;
    logic               hit_ctrl;
    logic               hit_idx;
    logic               hit_rbd;
    code_t              new_in;
    code_t              new_off;
    gain_t              new_gain;
    code_t              new_corr;
    code_t              rb_val;
    logic [14:0]        inc_sum;
    logic [27:0]        prod;
    logic signed [17:0] corr_s;

    decode_if dif ();

    instr_decoder u_dec (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .load    (wr_instr),
        .instr   (pwdata[`INSTR_SEL_MSB:0]),
        .dq      (dif.dec)
    );

    // register map decode
    assign hit_instr = hit(paddr, `REG_INSTR);
    assign hit_stat  = hit(paddr, `REG_STATUS);
    assign hit_ctrl  = hit(paddr, `REG_CTRL);
    assign hit_idx   = hit(paddr, `REG_RB_INDEX);
    assign hit_rbd   = hit(paddr, `REG_RB_DATA);
    assign mapped    = hit_instr || hit_stat || hit_ctrl || hit_idx || hit_rbd;

    // apb access completes at the edge where ready_q is seen
    assign commit   = psel && penable && ready_q;
    // an instruction is taken only when its answer carries no error
    assign wr_instr = commit && pwrite && hit_instr && !err_q;

    // readback selection
    always_comb begin
        case (rb_q[`RB_KIND_MSB:`RB_KIND_LSB])
            2'h0:    rb_val = input_mem[rb_q[`RB_CH_MSB:0]];
            2'h1:    rb_val = offset_mem[rb_q[`RB_CH_MSB:0]];
            2'h2:    rb_val = {1'b0, gain_mem[rb_q[`RB_CH_MSB:0]]};
            default: rb_val = corr_mem[rb_q[`RB_CH_MSB:0]];
        endcase
    end

    // apb answer, registered one edge into the access phase
    always_comb begin
        ready_d = psel && penable && !ready_q;
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        if (ready_d) begin
            if (!mapped) begin
                err_d = 1'b1;
            end else if (pwrite) begin
                err_d = hit_stat || hit_rbd || (hit_instr && state_q != ST_IDLE);
            end else if (hit_stat) begin
                rdata_d[`STAT_BUSY_BIT] = !busy_n_q;
                rdata_d[`STAT_GND_BIT]  = gnd_q;
            end else if (hit_idx) begin
                rdata_d[`RB_KIND_MSB:0] = rb_q;
            end else if (hit_rbd) begin
                rdata_d[13:0] = rb_val;
            end
        end
    end

    // per-channel update for the channel under the engine
    always_comb begin
        new_in   = input_mem[ch_q];
        new_off  = offset_mem[ch_q];
        new_gain = gain_mem[ch_q];
        inc_sum  = {1'b0, input_mem[ch_q]} + {8'h00, dif.step};
        case (dif.dest)
            DEST_INPUT:  new_in   = dif.data;
            DEST_OFFSET: new_off  = dif.data;
            DEST_GAIN:   new_gain = dif.data[13:1];
            DEST_SPECIAL: begin
                if (dif.step_up) begin
                    new_in = inc_sum[14] ? `CODE_MAX : inc_sum[13:0];
                end else if ({7'h00, dif.step} > input_mem[ch_q]) begin
                    new_in = 14'h0000;
                end else begin
                    new_in = input_mem[ch_q] - {7'h00, dif.step};
                end
            end
            default: new_in = input_mem[ch_q];
        endcase
        // corrected = in * (gain+1) / 8192 + offset - 8192, clamped
        prod   = {14'h0000, new_in} * {14'h0000, {1'b0, new_gain} + 14'h0001};
        corr_s = $signed({3'b000, prod[27:`GAIN_SHIFT]}) + $signed({4'h0, new_off})
                 - `OFFSET_MID;
        // clamp to the code range
        if (corr_s < 0) begin
            new_corr = 14'h0000;
        end else if (corr_s > $signed({4'h0, `CODE_MAX})) begin
            new_corr = `CODE_MAX;
        end else begin
            new_corr = corr_s[13:0];
        end
    end

    // storage write strobes
    assign mem_we  = (state_q == ST_RUN) && dif.mask[ch_q]
                     && (dif.dest != DEST_SPECIAL || dif.sfr_ok);
    assign mem_clr = (state_q == ST_DEC) && dif.soft_rst;

    // engine
    always_comb begin
        state_d  = state_q;
        ch_d     = ch_q;
        cnt_d    = cnt_q;
        busy_n_d = busy_n_q;
        gnd_d    = gnd_q;
        rb_d     = rb_q;
        // readback index write
        if (commit && pwrite && hit_idx) begin
            rb_d = pwdata[`RB_KIND_MSB:0];
        end
        if (commit && pwrite && hit_ctrl && pwdata[`CTRL_REL_BIT]) begin
            gnd_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (wr_instr) begin
                    state_d  = ST_DEC;
                    busy_n_d = 1'b0;
                end
            end
            ST_DEC: begin
                ch_d = 5'h00;
                // soft reset skips the channel sweep
                if (dif.soft_rst) begin
                    state_d = ST_SRST;
                    cnt_d   = CNT_W'(SOFT_RST_CYCLES - 1);
                    gnd_d   = 1'b1;
                end else begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                ch_d = ch_q + 5'h01;
                if (ch_q == 5'h1f) begin
                    state_d  = ST_IDLE;
                    busy_n_d = 1'b1;
                end
            end
            ST_SRST: begin
                // busy stays low while the counter runs down
                cnt_d = cnt_q - CNT_W'(1);
                if (cnt_q == '0) begin
                    state_d  = ST_IDLE;
                    busy_n_d = 1'b1;
                end
            end
            default: begin
                state_d  = ST_IDLE;
                busy_n_d = 1'b1;
            end
        endcase
    end

    // engine registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            ch_q     <= 5'h00;
            cnt_q    <= '0;
            busy_n_q <= 1'b1;
            gnd_q    <= 1'b0;
            rb_q     <= 7'h00;
        end else if (ce) begin
            state_q  <= state_d;
            ch_q     <= ch_d;
            cnt_q    <= cnt_d;
            busy_n_q <= busy_n_d;
            gnd_q    <= gnd_d;
            rb_q     <= rb_d;
        end
    end

    // apb answer registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else if (ce) begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    // next contents of the channel storage
    always_comb begin
        input_d  = input_mem;
        offset_d = offset_mem;
        gain_d   = gain_mem;
        corr_d   = corr_mem;
        if (mem_clr) begin
            for (int i = 0; i < 32; i++) begin
                input_d[i]  = `INPUT_RST;
                offset_d[i] = `OFFSET_RST;
                gain_d[i]   = `GAIN_RST;
                corr_d[i]   = `CORR_RST;
            end
        end else if (mem_we) begin
            input_d[ch_q]  = new_in;
            offset_d[ch_q] = new_off;
            gain_d[ch_q]   = new_gain;
            corr_d[ch_q]   = new_corr;
        end
    end

    // storage registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                input_mem[i]  <= `INPUT_RST;
                offset_mem[i] <= `OFFSET_RST;
                gain_mem[i]   <= `GAIN_RST;
                corr_mem[i]   <= `CORR_RST;
            end
        end else if (ce) begin
            input_mem  <= input_d;
            offset_mem <= offset_d;
            gain_mem   <= gain_d;
            corr_mem   <= corr_d;
        end
    end

    // outputs straight from registers
    assign prdata    = rdata_q;
    assign pready    = ready_q;
    assign pslverr   = err_q;
    assign busy_n    = busy_n_q;
    assign at_ground = gnd_q;
endmodule

// ---- verification/dwd_checker.sv ----
module dwd_checker #(
    parameter int SOFT_RST_CYCLES = 20
)(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status
    input wire logic        busy_n,
    input wire logic        at_ground
);
    int   lo_d;
    int   lo_q;
    logic wr_ok;
    logic ins_ok;

    assign wr_ok  = psel && penable && pready && pwrite && !pslverr;
    assign ins_ok = wr_ok && paddr == 12'h000;

    // length of the current busy stretch
    always_comb lo_d = busy_n ? 0 : lo_q + 1;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            lo_q <= 0;
        else
            lo_q <= lo_d;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_ready_two_cycles: assert property (psel && !penable && ce |-> ##2 pready)
        else $error("pready not two cycles after setup");
    chk_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_unmapped_error: assert property (pready && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_busy_start: assert property (ins_ok |=> !busy_n)
        else $error("busy not raised by instruction");
    chk_busy_span: assert property (ins_ok && pwdata[23:22] != 2'h0 |-> ##33 !busy_n ##1 busy_n)
        else $error("instruction busy span wrong");
    chk_busy_refuse: assert property (pready && pwrite && paddr == 12'h000 && !busy_n |-> pslverr)
        else $error("write while busy accepted");
    chk_ground_set: assert property (ins_ok && pwdata[23:22] == 2'h0 && pwdata[13:0] == 14'h3fff
        |-> ##[1:4] at_ground)
        else $error("soft reset did not ground outputs");
    chk_ground_clear: assert property ($fell(at_ground) |-> $past(wr_ok && paddr == 12'h008 && pwdata[0]))
        else $error("ground state left without clear");
    chk_srst_bound: assert property (lo_q <= SOFT_RST_CYCLES + 40)
        else $error("busy held too long");

    cover property (ins_ok && pwdata[23:22] == 2'h3);
    cover property ($rose(at_ground));
    cover property (pready && pslverr);
endmodule

bind dac_write_decoder dwd_checker #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES)) u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy_n(busy_n), .at_ground(at_ground)
);

// ---- verification/host_model.sv ----
module host_model (
    // clock
    input wire logic         sys_clk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input wire logic  [31:0] prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // wait ran out
    output logic             hung
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hung = 1'b0;
    end

    // one apb transfer, held until pready is seen at an edge or 50 access-phase edges pass, then hung is raised
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            hung <= 1'b1;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// ---- verification/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, nrst, ce;
    logic        psel, penable, pwrite, pready, pslverr, busy_n, at_ground, hung, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          n_fail, tests_run, c;

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    dac_write_decoder #(.SOFT_RST_CYCLES(20)) u_dac_write_decoder (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy_n(busy_n), .at_ground(at_ground));

    host_model u_host (
        .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));

    task automatic conclude;
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        u_host.xfer(1'b1, a, d, rd, err);
        chk({31'h0, err}, {31'h0, e});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
        u_host.xfer(1'b0, a, 32'h0, rd, err);
        chk({31'h0, err}, {31'h0, e});
        chk(rd, exp);
    endtask

    // bounded wait for the engine to finish
    task automatic idle;
        c = 0;
        repeat (2) @(posedge sys_clk);
        while (busy_n !== 1'b1 && c < 2000) begin
            @(posedge sys_clk);
            c++;
        end
        if (c >= 2000) begin
            n_fail++;
            $display("[ERR] %0t busy never ended", $time);
            conclude();
        end
    endtask

    task automatic ins(input logic [1:0] s, input logic [7:0] a, input logic [13:0] d);
        wr(12'h000, {8'h0, s, a, d}, 1'b0);
        idle();
    endtask

    task automatic rbk(input logic [4:0] ch, input logic [1:0] k, input logic [31:0] exp);
        wr(12'h00c, {25'h0, k, ch}, 1'b0);
        rdc(12'h010, exp, 1'b0);
    endtask

    function automatic logic [31:0] corr(int i, int g, int o);
        int v;
        v = ((i * (g + 1)) >> 13) + o - 8192;
        return (v < 0) ? 32'h0 : (v > 16383) ? 32'h3fff : 32'(v);
    endfunction

    always @(posedge hung) begin
        n_fail++;
        $display("[ERR] %0t no pready", $time);
        conclude();
    end

    initial begin
        n_fail = 0;
        tests_run = 0;
        nrst = 1'b0;
        ce = 1'b1;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rbk(5'd5, 2'd0, 32'h0);
        rbk(5'd5, 2'd1, 32'h2000);
        rbk(5'd5, 2'd2, 32'h1fff);
        rdc(12'h020, 32'h0, 1'b1);
        wr(12'h004, 32'h0, 1'b1);
        ins(2'h3, 8'h59, 14'h2abc);
        rbk(5'd7, 2'd0, 32'h2abc);
        rbk(5'd23, 2'd0, 32'h2abc);
        rbk(5'd15, 2'd0, 32'h0);
        ins(2'h3, 8'h26, 14'h1111);
        rbk(5'd14, 2'd0, 32'h0);
        ins(2'h2, 8'h0f, 14'h2005);
        rbk(5'd31, 2'd1, 32'h2005);
        rdc(12'h00c, 32'h0000_003f, 1'b0);
        ins(2'h1, 8'h00, 14'h1235);
        rbk(5'd0, 2'd2, 32'h091a);
        rbk(5'd7, 2'd3, corr(32'h2abc, 32'h091a, 32'h2005));
        ins(2'h3, 8'h10, 14'h3fc0);
        ins(2'h3, 8'h88, 14'h0123);
        rbk(5'd30, 2'd0, 32'h0123);
        ins(2'h0, 8'h10, 14'h017f);
        rbk(5'd0, 2'd0, 32'h3fff);
        ins(2'h0, 8'h10, 14'h007f);
        rbk(5'd0, 2'd0, 32'h3f80);
        ins(2'h0, 8'h19, 14'h0007);
        rbk(5'd7, 2'd0, 32'h2ab5);
        ins(2'h0, 8'h29, 14'h0005);
        rbk(5'd15, 2'd0, 32'h0);
        ins(2'h0, 8'h10, 14'h0301);
        rbk(5'd0, 2'd0, 32'h3f80);
        wr(12'h000, {8'h0, 2'h3, 8'h11, 14'h0aaa}, 1'b0);
        wr(12'h000, {8'h0, 2'h3, 8'h11, 14'h0bbb}, 1'b1);
        idle();
        rbk(5'd1, 2'd0, 32'h0aaa);
        wr(12'h000, {8'h0, 2'h0, 8'h12, 14'h0103}, 1'b0);
        ce <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk({31'h0, busy_n}, 32'h0);
        ce <= 1'b1;
        idle();
        rbk(5'd2, 2'd0, 32'h0003);
        ins(2'h0, 8'h00, 14'h3fff);
        chk({31'h0, c >= 20 && c <= 40}, 32'h1);
        rdc(12'h004, 32'h2, 1'b0);
        chk({31'h0, at_ground}, 32'h1);
        rbk(5'd7, 2'd0, 32'h0);
        rbk(5'd0, 2'd2, 32'h1fff);
        wr(12'h008, 32'h1, 1'b0);
        rdc(12'h004, 32'h0, 1'b0);
        chk({31'h0, at_ground}, 32'h0);
        conclude();
    end
endmodule
